// >>> hdl/ocp_params.svh
// constants of the oscillator control and power mode block
// assumes a 32-bit classic wishbone slave, byte addresses
`ifndef OCP_PARAMS_SVH
`define OCP_PARAMS_SVH
// register byte offsets
`define OCP_RC_OFS      8'h00
`define OCP_HXT_OFS     8'h04
`define OCP_LXT_OFS     8'h08
`define OCP_SYS_OFS     8'h0c
`define OCP_STAT_OFS    8'h10
// field positions
`define OCP_EN_BIT      0
`define OCP_FLAG_BIT    1
`define OCP_RANGE_BIT   2
`define OCP_FSEL_LSB    2
`define OCP_CKS_LSB     5
`define OCP_FHS_BIT     3
`define OCP_FSS_BIT     2
`define OCP_HKEEP_BIT   1
`define OCP_LKEEP_BIT   0
`define OCP_PDF_BIT     0
`define OCP_TO_BIT      1
`define OCP_MODE_LSB    2
// reset values
`define OCP_RC_EN_RST   1'b1
`define OCP_CTRL_RST    1'b0
`define OCP_CKS_RST     3'h0
// codes
`define OCP_CKS_SLOW    3'h7
// default stabilisation count in cycles
`define OCP_STAB_CYC    64
`endif

// >>> hdl/ocp_pkg.sv
// types of the oscillator control and power mode block
// assumes ocp_params.svh holds all numeric constants
package ocp_pkg;
   typedef enum logic [2:0] {
      MODE_FAST, MODE_SLOW, MODE_SLEEP, MODE_IDLE0, MODE_IDLE1, MODE_IDLE2
   } ocp_mode_type;
   typedef struct packed {
      logic internal_fast_rc;
      logic fast_crystal_osc;
      logic slow_crystal_osc;
      logic internal_slow_rc;
      logic sys_clk;
   } ocp_osc_run_type;
endpackage

// >>> hdl/ocp_top.sv
// oscillator enables, stable flags, fast/slow switching and halt modes
// assumes a classic wishbone master and a cpu issuing halt/wake pulses
//
// Operation
// - rc frequency code 00/01/10/11 gives 8/12/16/8 MHz
// - new rc frequency applies only once rc stable flag is set
// - rc enable or frequency change clears rc flag, sets it when stable
// - rc enable bit gates rc oscillator and resets to one
// - crystal range bit: 0 up to 10 MHz, 1 above
// - range change ignored while crystal pins enabled and crystal on
// - crystal enable clears crystal flag, sets it when stable
// - slow crystal enable clears its flag, sets it when stable
// - unused bits read zero, flags read-only, registers reset zero except rc enable
// - select 111 in fast mode switches to slow source
// - slow source picked by low select bit, switch waits for stable
// - from slow, codes 000-110 give fast clock divided 1 to 64
// - fast clock restart after slow mode watched through stable flag
// - halt with both keep bits low enters sleep
// - halt with fast keep low, slow keep high enters idle0
// - halt with both keep bits high enters idle1
// - halt with fast keep high, slow keep low enters idle2
// - halt stops program, state is retained
// - halt sets power-down flag and clears timeout flag
// - halt clears watchdog counter, which then keeps counting
// - high select picks rc or crystal, low select slow rc or crystal
// - slow internal rc runs whenever watchdog is enabled
`timescale 1ns/100ps
`include "ocp_params.svh"
module ocp_top #(
   parameter int STAB_CYC = `OCP_STAB_CYC
) (
   input  wire logic                 CLOCK_IN,
   input  wire logic                 RESETN_IN,
   input  wire logic                 CE_IN,
   input  wire logic                 WB_CYC_IN,
   input  wire logic                 WB_STB_IN,
   input  wire logic                 WB_WE_IN,
   input  wire logic [7:0]           WB_ADR_IN,
   input  wire logic [3:0]           WB_SEL_IN,
   input  wire logic [31:0]          WB_DAT_IN,
   output logic      [31:0]          WB_DAT_OUT,
   output logic                      WB_ACK_OUT,
   input  wire logic                 HALT_IN,
   input  wire logic                 WAKE_IN,
   input  wire logic                 WDT_EN_IN,
   input  wire logic                 WDT_TIMEOUT_IN,
   input  wire logic                 CLR_WDT_IN,
   input  wire logic                 XTAL_PINS_EN_IN,
   output ocp_pkg::ocp_osc_run_type  OSC_RUN_OUT,
   output logic      [7:0]           INTERNAL_FAST_RC_MHZ_OUT,
   output logic      [2:0]           SYSCLK_DIV_OUT,
   output logic                      SYSCLK_SLOW_OUT,
   output logic                      CPU_STOP_OUT,
   output logic                      WDT_CLEAR_OUT,
   output logic                      POWER_DOWN_FLAG_OUT,
   output logic                      WDT_TIMEOUT_FLAG_OUT
);
   import ocp_pkg::*;

   // rc frequency code to MHz
   function automatic logic [7:0] rc_mhz(input logic [1:0] code);
      case (code)
         2'h1:    rc_mhz = 8'h0c;
         2'h2:    rc_mhz = 8'h10;
         default: rc_mhz = 8'h08;
      endcase
   endfunction

   // *****************************************
   // state
   // *****************************************
   logic              rc_en_ff, hxt_en_ff, lxt_en_ff, hxt_range_ff;
   logic [1:0]        rc_fsel_ff, rc_fapp_ff;
   logic [2:0]        cks_ff, div_ff;
   logic              fhs_ff, fss_ff, hkeep_ff, lkeep_ff;
   logic              pdf_ff, to_ff, wdt_clr_ff, ack_ff;
   logic [31:0]       rdata_ff;
   logic [2:0]        flag_ff;
   logic [15:0]       cnt_ff [3];
   ocp_mode_type      mode_ff, nxt_mode;
   ocp_osc_run_type   run_ff, nxt_run;

   // *****************************************
   // wishbone decode
   // *****************************************
   wire acc   = WB_CYC_IN && WB_STB_IN;
   wire wr    = CE_IN && acc && ack_ff && WB_WE_IN && WB_SEL_IN[0];
   wire wr_rc = wr && (WB_ADR_IN == `OCP_RC_OFS);
   wire wr_hx = wr && (WB_ADR_IN == `OCP_HXT_OFS);
   wire wr_lx = wr && (WB_ADR_IN == `OCP_LXT_OFS);
   wire wr_sy = wr && (WB_ADR_IN == `OCP_SYS_OFS);
   wire [7:0] d = WB_DAT_IN[7:0];
   wire [1:0] new_fsel = d[`OCP_FSEL_LSB +: 2];

   // stabilisation restart requests
   wire rst_rc = wr_rc && ((d[`OCP_EN_BIT] && !rc_en_ff)
                           || (new_fsel != rc_fsel_ff));
   wire rst_hx = wr_hx && d[`OCP_EN_BIT] && !hxt_en_ff;
   wire rst_lx = wr_lx && d[`OCP_EN_BIT] && !lxt_en_ff;
   wire [2:0] restart = {rst_lx, rst_hx, rst_rc};
   // range frozen while crystal pins and crystal are on
   wire range_lock = XTAL_PINS_EN_IN && hxt_en_ff;

   // readback of each register
   wire [7:0] rd_rc = {4'h0, rc_fsel_ff, flag_ff[0], rc_en_ff};
   wire [7:0] rd_hx = {5'h00, hxt_range_ff, flag_ff[1], hxt_en_ff};
   wire [7:0] rd_lx = {6'h00, flag_ff[2], lxt_en_ff};
   wire [7:0] rd_sy = {cks_ff, 1'b0, fhs_ff, fss_ff, hkeep_ff, lkeep_ff};
   wire [7:0] rd_st = {3'h0, mode_ff, to_ff, pdf_ff};
   // unmapped and upper bits read zero
   wire [7:0] rd_sel = (WB_ADR_IN == `OCP_RC_OFS)   ? rd_rc :
                       (WB_ADR_IN == `OCP_HXT_OFS)  ? rd_hx :
                       (WB_ADR_IN == `OCP_LXT_OFS)  ? rd_lx :
                       (WB_ADR_IN == `OCP_SYS_OFS)  ? rd_sy :
                       (WB_ADR_IN == `OCP_STAT_OFS) ? rd_st : 8'h00;

   // *****************************************
   // clock source status
   // *****************************************
   // selected fast source
   wire hs_stable = fhs_ff ? flag_ff[1] : flag_ff[0];
   wire hs_src_en = fhs_ff ? hxt_en_ff : rc_en_ff;
   // slow rc taken as always ready once running
   wire ls_stable = fss_ff ? flag_ff[2] : 1'b1;
   wire run_mode  = (mode_ff == MODE_FAST) || (mode_ff == MODE_SLOW);
   wire hs_off    = (mode_ff == MODE_SLEEP) || (mode_ff == MODE_IDLE0);
   wire ls_off    = (mode_ff == MODE_SLEEP) || (mode_ff == MODE_IDLE2);
   wire halt_go   = CE_IN && HALT_IN && run_mode;
   wire [2:0] osc_on = {nxt_run.slow_crystal_osc, nxt_run.fast_crystal_osc,
                        nxt_run.internal_fast_rc};

   // *****************************************
   // bus slave: one wait state, registered data
   // *****************************************
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else if (CE_IN) begin
         ack_ff   <= acc && !ack_ff;
         rdata_ff <= {24'h00_0000, rd_sel};
      end
   end

   // *****************************************
   // control registers
   // *****************************************
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rc_en_ff     <= `OCP_RC_EN_RST;
         rc_fsel_ff   <= 2'h0;
         hxt_en_ff    <= `OCP_CTRL_RST;
         hxt_range_ff <= `OCP_CTRL_RST;
         lxt_en_ff    <= `OCP_CTRL_RST;
         cks_ff       <= `OCP_CKS_RST;
         fhs_ff       <= `OCP_CTRL_RST;
         fss_ff       <= `OCP_CTRL_RST;
         hkeep_ff     <= `OCP_CTRL_RST;
         lkeep_ff     <= `OCP_CTRL_RST;
      end else begin
         if (wr_rc) begin
            rc_en_ff   <= d[`OCP_EN_BIT];
            rc_fsel_ff <= new_fsel;
         end
         if (wr_hx) begin
            hxt_en_ff <= d[`OCP_EN_BIT];
            // range kept as written only while unlocked
            if (!range_lock)
               hxt_range_ff <= d[`OCP_RANGE_BIT];
         end
         if (wr_lx)
            lxt_en_ff <= d[`OCP_EN_BIT];
         if (wr_sy) begin
            cks_ff   <= d[`OCP_CKS_LSB +: 3];
            fhs_ff   <= d[`OCP_FHS_BIT];
            fss_ff   <= d[`OCP_FSS_BIT];
            hkeep_ff <= d[`OCP_HKEEP_BIT];
            lkeep_ff <= d[`OCP_LKEEP_BIT];
         end
      end
   end

   // *****************************************
   // stabilisation counters and stable flags
   // *****************************************
   // flag drops on restart or stop, rises after count
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         flag_ff <= 3'h0;
         for (int i = 0; i < 3; i++) begin
            cnt_ff[i] <= 16'h0000;
         end
      end else if (CE_IN) begin
         for (int i = 0; i < 3; i++) begin
            if (!osc_on[i] || restart[i]) begin
               cnt_ff[i]  <= 16'h0000;
               flag_ff[i] <= 1'b0;
            end else if (cnt_ff[i] == 16'(STAB_CYC - 1)) begin
               flag_ff[i] <= 1'b1;
            end else begin
               cnt_ff[i] <= cnt_ff[i] + 16'h0001;
            end
         end
      end
   end

   // applied rc frequency follows selection once stable
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN)
         rc_fapp_ff <= 2'h0;
      else if (CE_IN && flag_ff[0])
         rc_fapp_ff <= rc_fsel_ff;
   end

   // *****************************************
   // operating mode
   // *****************************************
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         MODE_FAST: begin
            if (HALT_IN)
               nxt_mode = hkeep_ff ? (lkeep_ff ? MODE_IDLE1 : MODE_IDLE2)
                                   : (lkeep_ff ? MODE_IDLE0 : MODE_SLEEP);
            else if (cks_ff == `OCP_CKS_SLOW && ls_stable)
               nxt_mode = MODE_SLOW;
         end
         MODE_SLOW: begin
            if (HALT_IN)
               nxt_mode = hkeep_ff ? (lkeep_ff ? MODE_IDLE1 : MODE_IDLE2)
                                   : (lkeep_ff ? MODE_IDLE0 : MODE_SLEEP);
            else if (cks_ff != `OCP_CKS_SLOW && hs_stable)
               nxt_mode = MODE_FAST;
         end
         // halt entry decode above
         default: begin
            if (WAKE_IN)
               nxt_mode = (cks_ff == `OCP_CKS_SLOW) ? MODE_SLOW : MODE_FAST;
         end
      endcase
   end

   // oscillator run enables per mode
   always_comb begin
      nxt_run.internal_fast_rc = rc_en_ff && !hs_off;
      nxt_run.fast_crystal_osc = hxt_en_ff && !hs_off;
      nxt_run.slow_crystal_osc = lxt_en_ff && !ls_off;
      // watchdog keeps slow rc alive
      nxt_run.internal_slow_rc = (!fss_ff && !ls_off) || WDT_EN_IN;
      // cpu clock only in fast or slow
      nxt_run.sys_clk = run_mode && (mode_ff == MODE_SLOW || hs_src_en);
   end

   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         mode_ff <= MODE_FAST;
         run_ff  <= '0;
         div_ff  <= `OCP_CKS_RST;
      end else if (CE_IN) begin
         mode_ff <= nxt_mode;
         run_ff  <= nxt_run;
         if (nxt_mode == MODE_FAST)
            div_ff <= cks_ff; // divide by 2**code
      end
   end

   // *****************************************
   // halt side effects on status and watchdog
   // *****************************************
   // halt set wins over clear-watchdog, timeout set wins over halt
   always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         pdf_ff     <= 1'b0;
         to_ff      <= 1'b0;
         wdt_clr_ff <= 1'b0;
      end else if (CE_IN) begin
         wdt_clr_ff <= HALT_IN && run_mode;
         if (halt_go)
            pdf_ff <= 1'b1;
         else if (CLR_WDT_IN)
            pdf_ff <= 1'b0;
         if (WDT_TIMEOUT_IN)
            to_ff <= 1'b1;
         else if (halt_go)
            to_ff <= 1'b0;
      end
   end

   // *****************************************
   // outputs
   // *****************************************
   assign WB_ACK_OUT           = ack_ff;
   assign WB_DAT_OUT           = rdata_ff;
   assign OSC_RUN_OUT          = run_ff;
   assign INTERNAL_FAST_RC_MHZ_OUT         = rc_mhz(rc_fapp_ff);
   assign SYSCLK_DIV_OUT       = div_ff;
   assign SYSCLK_SLOW_OUT      = (mode_ff == MODE_SLOW);
   assign CPU_STOP_OUT         = !run_mode;
   assign WDT_CLEAR_OUT        = wdt_clr_ff;
   assign POWER_DOWN_FLAG_OUT  = pdf_ff;
   assign WDT_TIMEOUT_FLAG_OUT = to_ff;

   // *****************************************
   // assertions
   // *****************************************
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESETN_IN);

   sequence s_drop(int i);
      ##1 !flag_ff[i];
   endsequence
   sequence s_halt;
      CE_IN && HALT_IN && run_mode;
   endsequence

   chk_rc_restart: assert property (CE_IN && rst_rc |-> s_drop(0))
      else $error("rc flag not cleared on restart");
   chk_hx_restart: assert property (CE_IN && rst_hx |-> s_drop(1))
      else $error("crystal flag not cleared on enable");
   chk_lx_restart: assert property (CE_IN && rst_lx |-> s_drop(2))
      else $error("slow crystal flag not cleared on enable");
   chk_rc_apply: assert property ($changed(rc_fapp_ff) |-> $past(flag_ff[0]))
      else $error("rc frequency applied while unstable");
   chk_freq_map: assert property (rc_fapp_ff == 2'h3 |-> INTERNAL_FAST_RC_MHZ_OUT == 8'h08)
      else $error("code 11 not mapped to 8 MHz");
   chk_range_lock: assert property (wr_hx && range_lock |=> $stable(hxt_range_ff))
      else $error("range changed while locked");
   chk_to_slow: assert property (CE_IN && mode_ff == MODE_FAST && !HALT_IN
      && cks_ff == `OCP_CKS_SLOW && ls_stable |=> SYSCLK_SLOW_OUT)
      else $error("no switch to slow mode");
   chk_slow_wait: assert property (mode_ff == MODE_FAST && fss_ff && !flag_ff[2]
      |=> mode_ff != MODE_SLOW)
      else $error("slow mode before slow crystal stable");
   chk_to_fast: assert property (CE_IN && mode_ff == MODE_SLOW && !HALT_IN
      && cks_ff != `OCP_CKS_SLOW && hs_stable |=> SYSCLK_DIV_OUT == $past(cks_ff))
      else $error("fast divider not applied");
   chk_sleep: assert property (s_halt ##0 !hkeep_ff && !lkeep_ff
      |=> mode_ff == MODE_SLEEP ##1 !OSC_RUN_OUT.sys_clk)
      else $error("sleep not entered");
   chk_idle0: assert property (s_halt ##0 !hkeep_ff && lkeep_ff |=> mode_ff == MODE_IDLE0)
      else $error("idle0 not entered");
   chk_idle1: assert property (s_halt ##0 hkeep_ff && lkeep_ff |=> mode_ff == MODE_IDLE1)
      else $error("idle1 not entered");
   chk_idle2: assert property (s_halt ##0 hkeep_ff && !lkeep_ff |=> mode_ff == MODE_IDLE2)
      else $error("idle2 not entered");
   chk_halt_flags: assert property (s_halt ##0 !WDT_TIMEOUT_IN
      |=> pdf_ff && !to_ff && CPU_STOP_OUT)
      else $error("halt flags wrong");
   chk_wdt_clear: assert property (s_halt |=> WDT_CLEAR_OUT ##1 !WDT_CLEAR_OUT)
      else $error("watchdog clear pulse wrong");
   chk_internal_slow_rc_wdt: assert property (CE_IN && WDT_EN_IN |=> OSC_RUN_OUT.internal_slow_rc)
      else $error("slow rc stopped with watchdog on");
   chk_rd_upper: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h00_0000
      && (WB_ADR_IN != `OCP_LXT_OFS || WB_DAT_OUT[7:2] == 6'h00))
      else $error("unused bits not zero");
   chk_stab_len: assert property (CE_IN && osc_on[0] && !restart[0]
      && cnt_ff[0] == 16'(STAB_CYC - 1) |=> flag_ff[0])
      else $error("rc flag late after count");
   chk_rc_reset: assert property ($rose(RESETN_IN) |-> rc_en_ff)
      else $error("rc enable not set after reset");
endmodule

// >>> tb/tb_top.sv
// self-checking bench of the oscillator control and power mode block
// assumes ocp_top with a one-cycle wishbone ack and a short stabilisation count
`timescale 1ns/100ps
`include "ocp_params.svh"
module tb_top;
   import ocp_pkg::*;
   localparam int STAB = 8;
   logic             clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic             halt = 1'b0, wake = 1'b0, wdt_en = 1'b0, wdt_to = 1'b0, clr_wdt = 1'b0;
   logic             pins = 1'b0;
   logic [7:0]       adr = 8'h00, mhz;
   logic [3:0]       sel = 4'h0;
   logic [31:0]      dat = 32'h0, rdata, rd_out;
   logic [2:0]       div;
   logic             ack, slow, stop, wclr, power_down_flag, tof;
   ocp_osc_run_type  run;
   int               fails = 0, comparisons = 0, seed = 22850;
   logic [2:0]       code;
   // ************************************************
   // clock, device under test
   // ************************************************
   always #2.5 clk = ~clk;
   ocp_top #(.STAB_CYC(STAB)) u_ocp_top (
      .CLOCK_IN(clk), .RESETN_IN(rst_n), .CE_IN(1'b1), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(rd_out),
      .WB_ACK_OUT(ack), .HALT_IN(halt), .WAKE_IN(wake), .WDT_EN_IN(wdt_en),
      .WDT_TIMEOUT_IN(wdt_to), .CLR_WDT_IN(clr_wdt), .XTAL_PINS_EN_IN(pins),
      .OSC_RUN_OUT(run), .INTERNAL_FAST_RC_MHZ_OUT(mhz), .SYSCLK_DIV_OUT(div), .SYSCLK_SLOW_OUT(slow),
      .CPU_STOP_OUT(stop), .WDT_CLEAR_OUT(wclr), .POWER_DOWN_FLAG_OUT(power_down_flag),
      .WDT_TIMEOUT_FLAG_OUT(tof));
   // ************************************************
   // helpers: expectations, compare, bus cycles
   // ************************************************
   function automatic logic [7:0] exp_mhz(input logic [1:0] c);
      exp_mhz = (c == 2'h1) ? 8'h0c : (c == 2'h2) ? 8'h10 : 8'h08;
   endfunction
   function automatic logic [2:0] exp_mode(input logic hk, input logic lk);
      exp_mode = hk ? (lk ? 3'h4 : 3'h5) : (lk ? 3'h3 : 3'h2);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      if (n == 20) begin
         fails++;
         complete_run();
      end
      rdata = rd_out;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
   endtask
   // poll a stable flag until set, bounded; a flag that never rises ends the run
   task automatic wait_flag(input logic [7:0] a);
      int n;
      for (n = 0; n < 40; n++) begin
         bus(1'b0, a, 32'h0);
         if (rdata[`OCP_FLAG_BIT] === 1'b1) break;
      end
      check({31'h0, rdata[`OCP_FLAG_BIT]}, 32'h1);
      if (rdata[`OCP_FLAG_BIT] !== 1'b1) complete_run();
   endtask
   // wait for the slow/fast mode output, bounded
   task automatic wait_slow(input logic v);
      int n;
      for (n = 0; n < 50 && slow !== v; n++) @(posedge clk);
      check({31'h0, slow}, {31'h0, v});
      if (slow !== v) complete_run();
   endtask
   // pulse codes, bits in order halt, wake, timeout, clear-watchdog
   localparam logic [3:0] pls_halt = 4'h8;
   localparam logic [3:0] pls_wake = 4'h4;
   localparam logic [3:0] pls_to   = 4'h2;
   localparam logic [3:0] pls_clr  = 4'h1;
   ocp_osc_run_type       exp_run;
   // one-cycle pulse; returns where the first response is visible
   task automatic pulse(input logic [3:0] which);
      {halt, wake, wdt_to, clr_wdt} <= which;
      @(posedge clk);
      {halt, wake, wdt_to, clr_wdt} <= 4'h0;
      @(posedge clk);
   endtask
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // reset values and an unmapped place
      bus(1'b0, `OCP_RC_OFS, 0);
      check(rdata & 32'hfd, 32'h01);
      bus(1'b0, `OCP_HXT_OFS, 0);
      check(rdata, 32'h0);
      bus(1'b0, `OCP_LXT_OFS, 0);
      check(rdata, 32'h0);
      bus(1'b0, `OCP_SYS_OFS, 0);
      check(rdata, 32'h0);
      check({24'h0, mhz}, 32'h08);
      bus(1'b1, 8'h14, 32'hff);
      bus(1'b0, 8'h14, 0);
      check(rdata, 32'h0);
      $display("test reset done");
      // rc frequency codes with random upper bits
      for (int i = 1; i <= 4; i++) begin
         bus(1'b1, `OCP_RC_OFS, ($random(seed) & 32'hfffffff0) | ((i % 4) << 2) | 32'h1);
         check({24'h0, mhz}, {24'h0, exp_mhz(2'((i - 1) % 4))});
         bus(1'b0, `OCP_RC_OFS, 0);
         check(rdata, 32'(((i % 4) << 2) | 1));
         wait_flag(`OCP_RC_OFS);
         check({24'h0, mhz}, {24'h0, exp_mhz(2'(i % 4))});
      end
      $display("test rc frequency done");
      // crystal range, enable, locked range, read-only flag
      pins <= 1'b1;
      bus(1'b1, `OCP_HXT_OFS, 32'hfe);
      bus(1'b0, `OCP_HXT_OFS, 0);
      check(rdata, 32'h04);
      bus(1'b1, `OCP_HXT_OFS, 32'h05);
      bus(1'b0, `OCP_HXT_OFS, 0);
      check(rdata, 32'h05);
      wait_flag(`OCP_HXT_OFS);
      bus(1'b1, `OCP_HXT_OFS, 32'h01);
      bus(1'b0, `OCP_HXT_OFS, 0);
      check(rdata, 32'h07);
      pins <= 1'b0;
      // slow crystal chosen while stopped: mode must stay fast
      bus(1'b1, `OCP_SYS_OFS, 32'he4);
      repeat (4) @(posedge clk);
      check({31'h0, slow}, 32'h0);
      bus(1'b1, `OCP_LXT_OFS, 32'hfd);
      bus(1'b0, `OCP_LXT_OFS, 0);
      check(rdata, 32'h01);
      wait_flag(`OCP_LXT_OFS);
      wait_slow(1'b1);
      $display("test crystals done");
      // fast to slow and back, both slow sources, random divider codes
      for (int i = 0; i < 4; i++) begin
         code = 3'($unsigned($random(seed)) % 7);
         if (i == 3) code = 3'h6;
         bus(1'b1, `OCP_SYS_OFS, 32'he0 | ((i & 1) << `OCP_FSS_BIT));
         wait_slow(1'b1);
         bus(1'b1, `OCP_SYS_OFS, 32'(code) << `OCP_CKS_LSB);
         wait_slow(1'b0);
         check({29'h0, div}, {29'h0, code});
      end
      $display("test clock switching done");
      // halt into each low-power mode, then wake
      for (int k = 0; k < 4; k++) begin
         wdt_en <= 1'($random(seed));
         bus(1'b1, `OCP_SYS_OFS, 32'(k));
         pulse(pls_to);
         check({31'h0, tof}, 32'h1);
         pulse(pls_halt);
         check({30'h0, stop, wclr}, 32'h3);
         check({30'h0, power_down_flag, tof}, 32'h2);
         @(posedge clk);
         check({31'h0, wclr}, 32'h0);
         exp_run = '{k[1], k[1], k[0], k[0] | wdt_en, 1'b0};
         check(32'(run), 32'(exp_run));
         bus(1'b0, `OCP_STAT_OFS, 0);
         check(rdata, {27'h0, exp_mode(k[1], k[0]), 2'h1});
         pulse(pls_halt);
         bus(1'b0, `OCP_STAT_OFS, 0);
         check(rdata[4:2], {29'h0, exp_mode(k[1], k[0])});
         pulse(pls_wake);
         check({31'h0, stop}, 32'h0);
         bus(1'b0, `OCP_SYS_OFS, 0);
         check(rdata, 32'(k));
         check({31'h0, run.sys_clk}, 32'h1);
         pulse(pls_clr);
         check({31'h0, power_down_flag}, 32'h0);
         wait_flag(`OCP_RC_OFS);
      end
      $display("test halt modes done");
      complete_run();
   end
endmodule
